// File: pkg/osf_pkg.sv
// Constants shared by the output status functions block
package osf_pkg;
    // --------------------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OSF_CTRL_OFF = 8'h00;
    localparam logic [7:0] OSF_PV_LOW_OFF = 8'h04;
    localparam logic [7:0] OSF_PV_HIGH_OFF = 8'h08;
    localparam logic [7:0] OSF_SETPOINT_OFF = 8'h0c;
    localparam logic [7:0] OSF_PERIOD_OFF = 8'h10;
    localparam logic [7:0] OSF_STATE_OFF = 8'h14;
    localparam logic [7:0] OSF_IRQ_STAT_OFF = 8'h18;
    localparam logic [7:0] OSF_IRQ_MASK_OFF = 8'h1c;
    // --------------------------------------------------------------
    // Field positions and reset values
    // --------------------------------------------------------------
    localparam int OSF_CTRL_FUNC_LSB = 0;
    localparam int OSF_CTRL_RESP_LSB = 8;
    localparam int OSF_RESP_TRIP_BIT = 0;
    localparam int OSF_RESP_COAST_BIT = 1;
    localparam int OSF_ST_BOOST_BIT = 0;
    localparam int OSF_ST_LOSS_BIT = 1;
    localparam int OSF_ST_RUN_BIT = 2;
    localparam int OSF_ST_PV_LSB = 16;
    localparam int OSF_IRQ_BOOST_BIT = 0;
    localparam int OSF_IRQ_LOSS_BIT = 1;
    localparam logic [7:0] OSF_FUNC_RST = 8'h07;
    localparam logic [1:0] OSF_RESP_RST = 2'h0;
    localparam logic [15:0] OSF_PV_LOW_RST = 16'h0000;
    localparam logic [15:0] OSF_PV_HIGH_RST = 16'h2710;
    localparam logic [15:0] OSF_SETPOINT_RST = 16'h0000;
    localparam logic [15:0] OSF_PERIOD_RST = 16'h0000;
    localparam logic [1:0] OSF_IRQ_RST = 2'h0;
    // --------------------------------------------------------------
    // Output function codes, trip code and bus response codes
    // --------------------------------------------------------------
    localparam logic [7:0] OSF_FUNC_BOOST = 8'h07;
    localparam logic [7:0] OSF_FUNC_LOSS = 8'h08;
    localparam logic [7:0] OSF_LINK_TIMEOUT_TRIP_CODE = 8'h3c;
    localparam logic [1:0] OSF_RESP_OKAY = 2'h0;
    localparam logic [1:0] OSF_RESP_SLVERR = 2'h2;
    // --------------------------------------------------------------
    // Timing: watchdog time base of 10 ms at 200 MHz
    // --------------------------------------------------------------
    localparam int OSF_CLK_MHZ = 200;
    localparam int OSF_TICK_MS = 10;
    localparam int OSF_TICK_CYCLES = OSF_TICK_MS * OSF_CLK_MHZ * 1000;
    localparam int OSF_TICK_W = 21;
endpackage

// File: pkg/osf_wdog_if.sv
// Signals between the top and the link watchdog
`timescale 1ns/10ps
interface osf_wdog_if;
    logic tick;
    logic frame_ok;
    logic [15:0] period;
    logic timed_out;
    logic [15:0] count;
    modport ctl (output tick, output frame_ok, output period, input timed_out, input count);
    modport wd (input tick, input frame_ok, input period, output timed_out, output count);
endinterface

// File: hdl/osf_watchdog.sv
// Serial link watchdog counting time base ticks
`timescale 1ns/10ps
module osf_watchdog
    import osf_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    osf_wdog_if.wd wdi
);
    // --------------------------------------------------------------
    // Tick counter
    // --------------------------------------------------------------
    logic [15:0] count;
    logic timed_out;
    wire disabled = (wdi.period == 16'h0000);
    wire [15:0] count_inc = count + 16'h0001;
    wire expire = wdi.tick & ~timed_out & (count_inc >= wdi.period);
    assign wdi.timed_out = timed_out;
    assign wdi.count = count;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 16'h0000;
            timed_out <= 1'b0;
        end else if (wdi.frame_ok || disabled) begin
            count <= 16'h0000;
            timed_out <= 1'b0;
        end else if (wdi.tick && !timed_out) begin
            count <= count_inc;
            timed_out <= expire;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wd_expire_at_a: assert property ($rose(timed_out) |-> $past(count) + 16'h0001 >= $past(wdi.period))
        else $error("Watchdog expired early");
    wd_frame_kick_a: assert property (wdi.frame_ok |=> !timed_out && count == 16'h0000)
        else $error("Frame did not restart watchdog");
    wd_disabled_a: assert property (disabled |=> !timed_out)
        else $error("Disabled watchdog timed out");
    wd_bound_a: assert property (!timed_out && wdi.period != 16'h0000 |-> count < wdi.period)
        else $error("Count passed period without time-out");
endmodule

// File: hdl/osf_top.sv
// Output status functions: boost output, link-loss output, AXI4-Lite registers
`timescale 1ns/10ps
module osf_top
    import osf_pkg::*;
#(
    parameter int TICK_CYCLES = OSF_TICK_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic forward_run_command,
    input wire logic [15:0] pv_value,
    input wire logic frame_ok,
    output logic pv_boost_output,
    output logic link_loss_output,
    output logic term_out,
    output logic trip_request,
    output logic [7:0] trip_code,
    output logic decel_stop_request,
    output logic coast_stop_request,
    output logic irq
);
    // --------------------------------------------------------------
    // Configuration registers
    // --------------------------------------------------------------
    logic [7:0] term_func;
    logic [1:0] link_error_response;
    logic [15:0] pv_low_limit;
    logic [15:0] pv_high_limit;
    logic [15:0] pid_setpoint;
    logic [15:0] link_timeout_period;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;

    // --------------------------------------------------------------
    // Run command synchroniser
    // --------------------------------------------------------------
    logic run_meta;
    logic run_state;
    logic run_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_meta <= 1'b0;
            run_state <= 1'b0;
            run_prev <= 1'b0;
        end else begin
            run_meta <= forward_run_command;
            run_state <= run_meta;
            run_prev <= run_state;
        end
    end

    wire run_to_stop = run_prev & ~run_state;

    // --------------------------------------------------------------
    // Boost output with hysteresis
    // --------------------------------------------------------------
    wire pv_below_low = (pv_value < pv_low_limit);
    wire pv_above_high = (pv_value > pv_high_limit);
    wire boost_set = run_state & pv_below_low;
    logic next_boost;

    always_comb begin
        next_boost = pv_boost_output;
        if (run_to_stop) begin
            next_boost = 1'b0;
        end else if (boost_set) begin
            next_boost = 1'b1;
        end else if (pv_above_high) begin
            next_boost = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pv_boost_output <= 1'b0;
        end else begin
            pv_boost_output <= next_boost;
        end
    end

    // --------------------------------------------------------------
    // Watchdog time base and instance
    // --------------------------------------------------------------
    osf_wdog_if wdi ();
    logic [OSF_TICK_W-1:0] tick_cnt;
    logic tick;
    localparam logic [OSF_TICK_W-1:0] TICK_LAST = OSF_TICK_W'(TICK_CYCLES - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == TICK_LAST);
            tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + OSF_TICK_W'(1);
        end
    end

    assign wdi.tick = tick;
    assign wdi.frame_ok = frame_ok;
    assign wdi.period = link_timeout_period;

    osf_watchdog u_wd (
        .aclk(aclk),
        .aresetn(aresetn),
        .wdi(wdi)
    );

    // --------------------------------------------------------------
    // Link-loss output and time-out response
    // --------------------------------------------------------------
    wire resp_trip = link_error_response[OSF_RESP_TRIP_BIT];
    wire resp_coast = link_error_response[OSF_RESP_COAST_BIT];
    wire sel_boost = (term_func == OSF_FUNC_BOOST);
    wire sel_loss = (term_func == OSF_FUNC_LOSS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_loss_output <= 1'b0;
            trip_request <= 1'b0;
            trip_code <= 8'h00;
            decel_stop_request <= 1'b0;
            coast_stop_request <= 1'b0;
            term_out <= 1'b0;
        end else begin
            link_loss_output <= wdi.timed_out;
            trip_request <= wdi.timed_out & resp_trip;
            trip_code <= (wdi.timed_out & resp_trip) ? OSF_LINK_TIMEOUT_TRIP_CODE : 8'h00;
            decel_stop_request <= wdi.timed_out & ~resp_coast;
            coast_stop_request <= wdi.timed_out & resp_coast;
            term_out <= (sel_boost & next_boost) | (sel_loss & wdi.timed_out);
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite write path
    // --------------------------------------------------------------
    logic aw_full;
    logic w_full;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire b_hs = s_axi_bvalid & s_axi_bready;
    wire do_write = aw_full & w_full & ~s_axi_bvalid;
    wire wr_full_word = (wr_strb == 4'hf);
    wire wr_mapped = (wr_addr[1:0] == 2'h0) && (wr_addr <= OSF_IRQ_MASK_OFF) && (wr_addr != OSF_STATE_OFF);
    wire wr_ctrl = do_write & wr_full_word & (wr_addr == OSF_CTRL_OFF);
    wire wr_low = do_write & wr_full_word & (wr_addr == OSF_PV_LOW_OFF);
    wire wr_high = do_write & wr_full_word & (wr_addr == OSF_PV_HIGH_OFF);
    wire wr_sp = do_write & wr_full_word & (wr_addr == OSF_SETPOINT_OFF);
    wire wr_period = do_write & wr_full_word & (wr_addr == OSF_PERIOD_OFF);
    wire wr_istat = do_write & wr_full_word & (wr_addr == OSF_IRQ_STAT_OFF);
    wire wr_imask = do_write & wr_full_word & (wr_addr == OSF_IRQ_MASK_OFF);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= OSF_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                s_axi_awready <= 1'b0;
                aw_full <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full <= 1'b0;
            end else if (b_hs) begin
                s_axi_awready <= 1'b1;
            end
            if (w_hs) begin
                s_axi_wready <= 1'b0;
                w_full <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_full <= 1'b0;
            end else if (b_hs) begin
                s_axi_wready <= 1'b1;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? OSF_RESP_OKAY : OSF_RESP_SLVERR;
            end else if (b_hs) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            term_func <= OSF_FUNC_RST;
            link_error_response <= OSF_RESP_RST;
            pv_low_limit <= OSF_PV_LOW_RST;
            pv_high_limit <= OSF_PV_HIGH_RST;
            pid_setpoint <= OSF_SETPOINT_RST;
            link_timeout_period <= OSF_PERIOD_RST;
            irq_mask <= OSF_IRQ_RST;
        end else begin
            if (wr_ctrl) begin
                term_func <= wr_data[OSF_CTRL_FUNC_LSB +: 8];
                link_error_response <= wr_data[OSF_CTRL_RESP_LSB +: 2];
            end
            if (wr_low) pv_low_limit <= wr_data[15:0];
            if (wr_high) pv_high_limit <= wr_data[15:0];
            if (wr_sp) pid_setpoint <= wr_data[15:0];
            if (wr_period) link_timeout_period <= wr_data[15:0];
            if (wr_imask) irq_mask <= wr_data[1:0];
        end
    end

    // --------------------------------------------------------------
    // Interrupt status, set wins over clear
    // --------------------------------------------------------------
    wire [1:0] irq_events = {~link_loss_output & wdi.timed_out, ~pv_boost_output & next_boost};
    wire [1:0] irq_clear = wr_istat ? wr_data[1:0] : 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= OSF_IRQ_RST;
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clear) | irq_events;
            irq <= |(((irq_stat & ~irq_clear) | irq_events) & irq_mask);
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite read path
    // --------------------------------------------------------------
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire r_hs = s_axi_rvalid & s_axi_rready;
    logic [31:0] rd_word;
    logic rd_ok;

    always_comb begin
        rd_word = 32'h00000000;
        rd_ok = (s_axi_araddr[1:0] == 2'h0);
        case (s_axi_araddr)
            OSF_CTRL_OFF: rd_word = {22'h000000, link_error_response, term_func};
            OSF_PV_LOW_OFF: rd_word = {16'h0000, pv_low_limit};
            OSF_PV_HIGH_OFF: rd_word = {16'h0000, pv_high_limit};
            OSF_SETPOINT_OFF: rd_word = {16'h0000, pid_setpoint};
            OSF_PERIOD_OFF: rd_word = {16'h0000, link_timeout_period};
            OSF_STATE_OFF: rd_word = {pv_value, 13'h0000, run_state, link_loss_output, pv_boost_output};
            OSF_IRQ_STAT_OFF: rd_word = {30'h00000000, irq_stat};
            OSF_IRQ_MASK_OFF: rd_word = {30'h00000000, irq_mask};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= OSF_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? OSF_RESP_OKAY : OSF_RESP_SLVERR;
        end else if (r_hs) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    boost_set_a: assert property (run_state && !run_to_stop && pv_below_low |=> pv_boost_output)
        else $error("Boost not set below low limit in run");
    boost_clear_a: assert property (pv_above_high && !boost_set |=> !pv_boost_output)
        else $error("Boost not cleared above high limit");
    stop_clear_a: assert property ($fell(run_state) |=> !pv_boost_output)
        else $error("Boost not cleared on stop");
    boost_hold_a: assert property (!pv_below_low && !pv_above_high && !run_to_stop |=> $stable(pv_boost_output))
        else $error("Boost changed between limits");
    trip_link_only_a: assert property (trip_request |-> link_loss_output && trip_code == OSF_LINK_TIMEOUT_TRIP_CODE)
        else $error("Trip without link time-out");
    stop_excl_a: assert property (!(decel_stop_request && coast_stop_request)
        && (coast_stop_request || decel_stop_request) == link_loss_output)
        else $error("Time-out response inconsistent");
    zero_period_a: assert property (link_timeout_period == 16'h0000 [*3] |-> !link_loss_output)
        else $error("Link loss with watchdog disabled");
    frame_clear_a: assert property (frame_ok |=> ##1 !link_loss_output)
        else $error("Link loss held after frame");
    irq_level_a: assert property (irq |-> $past(irq_mask) != 2'h0)
        else $error("Interrupt with all sources masked");
endmodule

// File: tb/osf_link_master.sv
// Serial network master model sending good-frame pulses at a fixed gap
`timescale 1ns/10ps
module osf_link_master (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic en,
    input wire logic [7:0] gap,
    output logic frame_ok
);
    // --------------------------------------------------------------
    // Frame pacing
    // --------------------------------------------------------------
    logic [7:0] cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || !en) begin
            cnt <= 8'h00;
            frame_ok <= 1'h0;
        end else if (cnt == gap - 8'h01) begin
            cnt <= 8'h00;
            frame_ok <= 1'h1;
        end else begin
            cnt <= cnt + 8'h01;
            frame_ok <= 1'h0;
        end
    end
endmodule

// File: tb/osf_top_tb.sv
// Self-checking bench for the output status functions block
`timescale 1ns/10ps
module osf_top_tb;
    import osf_pkg::*;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    localparam int TK = 10;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic run = 1'h0, link_en = 1'h0;
    logic [15:0] pv = 16'h0000;
    logic awready, wready, bvalid, arready, rvalid, frame_ok;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    logic boost, loss, term, trip, decel, coast, irq;
    logic [7:0] tcode;
    int n_errors = 0;
    int total_checks = 0;
    always #2.5 aclk = ~aclk;
    osf_top #(.TICK_CYCLES(TK)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .forward_run_command(run), .pv_value(pv),
        .frame_ok(frame_ok), .pv_boost_output(boost), .link_loss_output(loss), .term_out(term),
        .trip_request(trip), .trip_code(tcode), .decel_stop_request(decel),
        .coast_stop_request(coast), .irq(irq));
    osf_link_master link_u (.aclk(aclk), .aresetn(aresetn), .en(link_en), .gap(8'h0f),
        .frame_ok(frame_ok));
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && bready) begin
                done = 1'h1;
                bready <= 1'h0;
                chk("bresp", 32'(er), 32'(bresp));
                chk("write taken", 32'h0, 32'({awvalid, wvalid}));
            end
        end
    endtask
    task automatic rdr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        logic done;
        done = 1'h0;
        d = 32'hx;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && rready) begin
                done = 1'h1;
                d = rdata;
                rready <= 1'h0;
                chk("rresp", 32'(er), 32'(rresp));
            end
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        rdr(a, OSF_RESP_OKAY, d);
        chk(name, exp, d);
    endtask
    task automatic wait_loss(input logic e);
        int n;
        n = 0;
        while (loss !== e && n < 80) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        rchk(OSF_CTRL_OFF, 32'(OSF_FUNC_RST), "ctrl reset");
        rchk(OSF_PV_HIGH_OFF, 32'h2710, "high reset");
        rchk(OSF_PERIOD_OFF, 32'h0, "period reset");
        rchk(OSF_IRQ_MASK_OFF, 32'h0, "mask reset");
        rdr(8'h20, OSF_RESP_SLVERR, rd);
        chk("unmapped data", 32'h0, rd);
        wr(OSF_STATE_OFF, 32'hf, OSF_RESP_SLVERR);
        wr(OSF_PV_LOW_OFF, 32'h0bb8, OSF_RESP_OKAY);
        wr(OSF_PV_HIGH_OFF, 32'h1b58, OSF_RESP_OKAY);
        wr(OSF_SETPOINT_OFF, 32'h1388, OSF_RESP_OKAY);
        rchk(OSF_SETPOINT_OFF, 32'h1388, "setpoint");
        wr(OSF_IRQ_MASK_OFF, 32'h3, OSF_RESP_OKAY);
        pv <= 16'h07d0;
        cyc(6);
        chk("boost idle", 32'h0, 32'(boost));
        run <= 1'h1;
        cyc(6);
        chk("boost on", 32'h1, 32'(boost));
        chk("term boost", 32'h1, 32'(term));
        chk("irq set", 32'h1, 32'(irq));
        rchk(OSF_IRQ_STAT_OFF, 32'h1, "irq stat");
        wr(OSF_IRQ_STAT_OFF, 32'h1, OSF_RESP_OKAY);
        rchk(OSF_IRQ_STAT_OFF, 32'h0, "irq clear");
        chk("irq low", 32'h0, 32'(irq));
        pv <= 16'h1388;
        cyc(6);
        chk("boost hold on", 32'h1, 32'(boost));
        pv <= 16'h1f40;
        cyc(6);
        chk("boost off", 32'h0, 32'(boost));
        chk("no trip", 32'h0, 32'(trip));
        pv <= 16'h0bb8;
        cyc(6);
        chk("boost hold off", 32'h0, 32'(boost));
        pv <= 16'h07d0;
        cyc(6);
        rchk(OSF_STATE_OFF, 32'h07d0_0005, "state");
        pv <= 16'h1388;
        run <= 1'h0;
        cyc(6);
        chk("boost stop", 32'h0, 32'(boost));
        pv <= 16'h07d0;
        cyc(6);
        chk("boost stopped", 32'h0, 32'(boost));
        wr(OSF_CTRL_OFF, 32'(OSF_FUNC_LOSS), OSF_RESP_OKAY);
        cyc(200);
        chk("wdog off", 32'h0, 32'(loss));
        chk("wdog off trip", 32'h0, 32'(trip));
        link_en <= 1'h1;
        wr(OSF_PERIOD_OFF, 32'h3, OSF_RESP_OKAY);
        rchk(OSF_PERIOD_OFF, 32'h3, "period");
        cyc(200);
        chk("link fed", 32'h0, 32'(loss));
        for (int r = 0; r < 4; r++) begin
            wr(OSF_CTRL_OFF, {22'h0, 2'(r), OSF_FUNC_LOSS}, OSF_RESP_OKAY);
            cyc(20);
            while (!frame_ok) @(posedge aclk);
            link_en <= 1'h0;
            cyc(15);
            chk("loss early", 32'h0, 32'(loss));
            wait_loss(1'h1);
            cyc(2);
            chk("loss on", 32'h1, 32'(loss));
            chk("term loss", 32'h1, 32'(term));
            chk("trip", 32'(r % 2), 32'(trip));
            chk("trip code", (r % 2) ? 32'h3c : 32'h0, 32'(tcode));
            chk("decel", 32'(r < 2), 32'(decel));
            chk("coast", 32'(r >= 2), 32'(coast));
            rchk(OSF_IRQ_STAT_OFF, 32'h3, "irq stat loss");
            wr(OSF_IRQ_STAT_OFF, 32'h2, OSF_RESP_OKAY);
            link_en <= 1'h1;
            wait_loss(1'h0);
            cyc(2);
            chk("loss cleared", 32'h0, 32'(loss));
            chk("trip cleared", 32'h0, 32'(trip));
        end
        summarize;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        summarize;
    end
endmodule
